// [design/ilsc_target.v]
// Two-wire bus target: write-only receiver, legacy address ignore, stretch time-out
`timescale 1ns/100ps
`include "ilsc_map.vh"
module ilsc_target #(
  parameter [`ILSC_TOCNT_W-1:0] TIMEOUT_CYC = `ILSC_TIMEOUT_CYC
) (
  // Clock and reset
  input wire CLK,
  input wire RST_N,
  // Bus pins
  input wire SCL_IN,
  output reg SCL_OUT,
  output reg SCL_OE,
  input wire SDA_IN,
  output reg SDA_OUT,
  output reg SDA_OE,
  // Configuration
  input wire SMBUS_MODE,
  // User side
  input wire BUSY,
  input wire [1:0] RD_ADDR,
  output wire [7:0] RD_DATA,
  output reg RX_VALID,
  output reg TIMEOUT,
  output reg LEGACY_ACTIVE
);
  localparam [4:0] ST_IDLE = 5'h01;
  localparam [4:0] ST_ADDR = 5'h02;
  localparam [4:0] ST_ACK = 5'h04;
  localparam [4:0] ST_DATA = 5'h08;
  localparam [4:0] ST_IGNORE = 5'h10;

  // Two-flop synchronisers; first stage read only by the second
  reg scl_m, scl_s, scl_d;
  reg sda_m, sda_s, sda_d;
  reg mode_m, mode_s;
  reg busy_m, busy_s;
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      scl_m <= 1'b1;
      scl_s <= 1'b1;
      scl_d <= 1'b1;
      sda_m <= 1'b1;
      sda_s <= 1'b1;
      sda_d <= 1'b1;
      mode_m <= 1'b0;
      mode_s <= 1'b0;
      busy_m <= 1'b0;
      busy_s <= 1'b0;
    end else begin
      scl_m <= SCL_IN;
      scl_s <= scl_m;
      scl_d <= scl_s;
      sda_m <= SDA_IN;
      sda_s <= sda_m;
      sda_d <= sda_s;
      mode_m <= SMBUS_MODE;
      mode_s <= mode_m;
      busy_m <= BUSY;
      busy_s <= busy_m;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_det = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_det = scl_s & scl_d & ~sda_d & sda_s;

  reg [4:0] state;
  reg [3:0] bit_cnt;
  reg [7:0] shift;
  reg [1:0] wr_ptr;
  reg wr_en;
  reg [7:0] wr_data;
  reg [`ILSC_TOCNT_W-1:0] low_cnt;
  reg stretching;
  wire timeout_hit = mode_s & stretching & (low_cnt >= TIMEOUT_CYC); // [RQ8] [RQ10]

  function addr_is_legacy;
    input [7:0] b;
    begin
      addr_is_legacy = (b[7:1] == `ILSC_LEGACY_ADDR);
    end
  endfunction

  // Clock-low counter: runs only while we ourselves hold the clock low
  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      low_cnt <= {`ILSC_TOCNT_W{1'b0}};
    end else if (stretching && mode_s) begin // [RQ10]
      low_cnt <= low_cnt + 1'b1;
    end else begin
      low_cnt <= {`ILSC_TOCNT_W{1'b0}};
    end
  end

  always @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state <= ST_IDLE;
      bit_cnt <= 4'h0;
      shift <= 8'h00;
      wr_ptr <= 2'h0;
      wr_en <= 1'b0;
      wr_data <= 8'h00;
      SDA_OUT <= 1'b0;
      SDA_OE <= 1'b0;
      SCL_OUT <= 1'b0;
      SCL_OE <= 1'b0;
      stretching <= 1'b0;
      RX_VALID <= 1'b0;
      TIMEOUT <= 1'b0;
      LEGACY_ACTIVE <= 1'b0;
    end else begin
      wr_en <= 1'b0;
      RX_VALID <= 1'b0;
      TIMEOUT <= 1'b0;
      // Advance the ring on the same edge as each store, whatever the bus does next
      if (wr_en) begin
        wr_ptr <= wr_ptr + 2'h1;
      end
      if (timeout_hit) begin
        // Drop the transfer and let go of both lines
        state <= ST_IDLE; // [RQ9]
        SDA_OE <= 1'b0; // [RQ9]
        SCL_OE <= 1'b0; // [RQ9]
        stretching <= 1'b0;
        TIMEOUT <= 1'b1;
        LEGACY_ACTIVE <= 1'b0;
      end else if (stop_det) begin
        state <= ST_IDLE; // [RQ4] [RQ5]
        SDA_OE <= 1'b0;
        SCL_OE <= 1'b0;
        stretching <= 1'b0;
        LEGACY_ACTIVE <= 1'b0; // [RQ5]
      end else if (start_det) begin
        state <= ST_ADDR;
        bit_cnt <= 4'h0;
        SDA_OE <= 1'b0;
        SCL_OE <= 1'b0;
        stretching <= 1'b0;
        LEGACY_ACTIVE <= 1'b0;
      end else begin
        case (state)
          ST_IDLE: begin
            SDA_OE <= 1'b0;
          end
          ST_ADDR, ST_DATA: begin
            if (scl_rise) begin
              shift <= {shift[6:0], sda_s};
              bit_cnt <= bit_cnt + 4'h1;
            end
            if (scl_fall && bit_cnt == `ILSC_BIT_ACK) begin
              bit_cnt <= 4'h0;
              if (state == ST_ADDR && addr_is_legacy(shift)) begin
                // Stay silent: no acknowledge, nothing driven until STOP or a new START
                state <= ST_IGNORE; // [RQ1] [RQ2] [RQ3]
                LEGACY_ACTIVE <= 1'b1;
              end else if (state == ST_ADDR &&
                           (shift[7:1] != `ILSC_OWN_ADDR || shift[0])) begin
                state <= ST_IGNORE;
              end else begin
                if (state == ST_DATA) begin
                  wr_en <= 1'b1;
                  wr_data <= shift;
                  RX_VALID <= 1'b1;
                end
                SDA_OUT <= 1'b0;
                SDA_OE <= 1'b1;
                state <= ST_ACK;
              end
            end
          end
          ST_ACK: begin
            if (scl_fall) begin
              SDA_OE <= 1'b0;
              if (busy_s) begin
                // Hold clock low while the user side is busy
                SCL_OUT <= 1'b0; // [RQ7]
                SCL_OE <= 1'b1; // [RQ7]
                stretching <= 1'b1;
              end
              state <= ST_DATA;
            end
          end
          ST_IGNORE: begin
            SDA_OE <= 1'b0; // [RQ1]
          end
          default: begin
            state <= ST_IDLE;
          end
        endcase
        if (stretching && !busy_s) begin
          SCL_OE <= 1'b0; // [RQ7]
          stretching <= 1'b0;
        end
      end
    end
  end

  ilsc_rxbuf u_rxbuf (
    .clk(CLK),
    .rst_n(RST_N),
    .wr_en(wr_en),
    .wr_addr(wr_ptr),
    .wr_data(wr_data),
    .rd_addr(RD_ADDR),
    .rd_data(RD_DATA)
  );
endmodule // ilsc_target

// [include/ilsc_map.vh]
// Constants for the two-wire target with legacy-address ignore and clock-low time-out
// Behaviour
// (RQ1) Never acknowledge or answer address whose upper seven bits are 0000001.
// (RQ2) Master may raise legacy data-line enable and send legacy-format data after it.
// (RQ3) Legacy-format receivers take data with no acknowledge bit or acknowledge clock.
// (RQ4) Master ends every legacy transfer with STOP; every device detects it.
// (RQ5) On STOP after a legacy transfer, return to idle, ready for START and address.
// (RQ6) Master keeps clock between 10 kHz and 100 kHz when timed-out targets exist.
// (RQ7) In plain mode the device may stretch the clock low without limit.
// (RQ8) In timed mode no single clock stretch lasts longer than 35 ms.
// (RQ9) On time-out, reset bus interface, release both lines, wait for new START.
// (RQ10) Static input selects timed mode; when low the time-out counter is off.
`ifndef ILSC_MAP_VH
`define ILSC_MAP_VH
`define ILSC_CLK_HZ 20000000
`define ILSC_TIMEOUT_MS 35
// 35 ms of clock cycles at 20 MHz, sized to the counter width
`define ILSC_TIMEOUT_CYC 20'hAAE60
`define ILSC_TOCNT_W 20
`define ILSC_LEGACY_ADDR 7'h01
`define ILSC_ADDR_W 7
`define ILSC_BIT_LAST 4'h7
`define ILSC_BIT_ACK 4'h8
`define ILSC_OWN_ADDR 7'h2A
`endif

// [design/ilsc_rxbuf.v]
// Small register file holding received bytes, registered read data
`timescale 1ns/100ps
module ilsc_rxbuf (
  // Clock and reset
  input wire clk,
  input wire rst_n,
  // Write side
  input wire wr_en,
  input wire [1:0] wr_addr,
  input wire [7:0] wr_data,
  // Read side
  input wire [1:0] rd_addr,
  output reg [7:0] rd_data
);
  reg [7:0] mem [0:3];
  always @(posedge clk) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rd_data <= 8'h00;
    end else begin
      rd_data <= mem[rd_addr];
    end
  end
endmodule // ilsc_rxbuf

// [verif/ilsc_monitor.sv]
// Port checker for the two-wire target
`timescale 1ns/100ps
module ilsc_monitor #(parameter [19:0] TIMEOUT_CYC = 20'hAAE60) (
  // Watched ports
  input wire CLK,
  input wire RST_N,
  input wire SCL_IN,
  input wire SDA_IN,
  input wire SMBUS_MODE,
  input wire BUSY,
  input wire SCL_OE,
  input wire SCL_OUT,
  input wire SDA_OE,
  input wire SDA_OUT,
  input wire RX_VALID,
  input wire TIMEOUT,
  input wire LEGACY_ACTIVE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);
  reg [19:0] st;
  always @(posedge CLK or negedge RST_N)
    if (!RST_N) st <= 20'h0;
    else st <= SCL_OE ? st + 20'h1 : 20'h0;
  sequence busy_held;
    BUSY [*4];
  endsequence
  lg_quiet_a: assert property (LEGACY_ACTIVE |-> !SDA_OE && !SCL_OE)
    else $error("legacy answered");
  lg_store_a: assert property (LEGACY_ACTIVE |-> !RX_VALID)
    else $error("legacy stored");
  lg_stop_a: assert property (LEGACY_ACTIVE && SCL_IN && $rose(SDA_IN) |-> ##[1:5] !LEGACY_ACTIVE)
    else $error("no idle after stop");
  plain_hold_a: assert property (busy_held ##0 (SCL_OE && !SMBUS_MODE) |=> SCL_OE)
    else $error("stretch cut short");
  smb_limit_a: assert property (SMBUS_MODE |-> st <= TIMEOUT_CYC + 20'h4)
    else $error("stretch too long");
  od_low_a: assert property (!(SCL_OE && SCL_OUT) && !(SDA_OE && SDA_OUT))
    else $error("line driven high");
  to_release_a: assert property (TIMEOUT |=> !SCL_OE && !SDA_OE)
    else $error("lines held after time-out");
  plain_no_to_a: assert property (!SMBUS_MODE |-> !TIMEOUT)
    else $error("time-out in plain mode");
endmodule // ilsc_monitor
bind ilsc_target ilsc_monitor #(.TIMEOUT_CYC(TIMEOUT_CYC)) u_mon (.CLK(CLK), .RST_N(RST_N),
  .SCL_IN(SCL_IN), .SDA_IN(SDA_IN), .SMBUS_MODE(SMBUS_MODE), .BUSY(BUSY), .SCL_OE(SCL_OE),
  .SCL_OUT(SCL_OUT), .SDA_OE(SDA_OE), .SDA_OUT(SDA_OUT), .RX_VALID(RX_VALID),
  .TIMEOUT(TIMEOUT), .LEGACY_ACTIVE(LEGACY_ACTIVE));

// [verif/ilsc_mst_model.sv]
// Bus master model on the open-drain lines
`timescale 1ns/100ps
module ilsc_mst_model (
  // Clock and line levels
  input wire CLK,
  input wire SCL,
  input wire SDA,
  // Drives, high releases the line
  output reg scl_o = 1'b1,
  output reg sda_o = 1'b1
);
  localparam HALF = 100; // 100 kHz at 20 MHz
  reg ack;
  // Third line for the legacy receiver; the target never looks at it
  reg legacy_data_line_enable = 1'b0;
  integer k;
  task hw(input integer n);
    repeat (n) @(negedge CLK);
  endtask
  task put(input b);
    begin
      sda_o = b;
      hw(HALF);
      scl_o = 1'b1;
      for (k = 0; !SCL && k < 5000; k = k + 1) hw(1);
      ack = SDA;
      hw(HALF);
      scl_o = 1'b0;
      hw(5);
    end
  endtask
  task cond(input a, input b);
    begin
      sda_o = a;
      hw(HALF);
      scl_o = 1'b1;
      hw(HALF);
      sda_o = b;
      hw(HALF);
    end
  endtask
  task start;
    begin
      cond(1'b1, 1'b0);
      scl_o = 1'b0;
      hw(5);
    end
  endtask
  task stop;
    begin
      cond(1'b0, 1'b1);
      legacy_data_line_enable = 1'b0;
    end
  endtask
  task send(input [7:0] d, input leg);
    integer i;
    begin
      legacy_data_line_enable = leg;
      for (i = 7; i >= 0; i = i - 1) put(d[i]);
      if (!legacy_data_line_enable) put(1'b1);
    end
  endtask
endmodule // ilsc_mst_model

// [verif/ilsc_target_tb_top.sv]
// Self-checking bench for the two-wire target
`timescale 1ns/100ps
module ilsc_target_tb_top;
  reg CLK = 1'b0;
  reg RST_N = 1'b0;
  reg SMBUS_MODE = 1'b0;
  reg BUSY = 1'b0;
  reg [1:0] RD_ADDR = 2'h0;
  wire scl_m, sda_m, scl_oe, sda_oe, RX_VALID, TIMEOUT, LEGACY_ACTIVE;
  wire [7:0] RD_DATA;
  // Pull-ups: a line is low while any party pulls it
  wire scl = scl_m & ~scl_oe;
  wire sda = sda_m & ~sda_oe;
  integer num_errors = 0, cmp_count = 0, cyc = 0, n_rx = 0, n_to = 0, n_ex = 0, i;
  reg [7:0] mem [0:3];
  always #25 CLK = ~CLK;
  ilsc_target #(.TIMEOUT_CYC(20'hC8)) u_dut (.CLK(CLK), .RST_N(RST_N), .SCL_IN(scl),
    .SCL_OUT(), .SCL_OE(scl_oe), .SDA_IN(sda), .SDA_OUT(), .SDA_OE(sda_oe),
    .SMBUS_MODE(SMBUS_MODE), .BUSY(BUSY), .RD_ADDR(RD_ADDR), .RD_DATA(RD_DATA),
    .RX_VALID(RX_VALID), .TIMEOUT(TIMEOUT), .LEGACY_ACTIVE(LEGACY_ACTIVE));
  ilsc_mst_model u_mst (.CLK(CLK), .SCL(scl), .SDA(sda), .scl_o(scl_m), .sda_o(sda_m));
  task tally_and_finish;
    begin
      $display("checks %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
    end
  endtask
  task chk(input [63:0] nm, input [7:0] e, input [7:0] g);
    begin
      cmp_count = cmp_count + 1;
      if (g !== e) begin
        num_errors = num_errors + 1;
        $display("MISMATCH %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  always @(posedge CLK) begin
    cyc = cyc + 1;
    if (RX_VALID === 1'b1) n_rx = n_rx + 1;
    if (TIMEOUT === 1'b1) n_to = n_to + 1;
    if (cyc == 60000) begin
      num_errors = num_errors + 1;
      tally_and_finish;
    end
  end
  // Sends n data bytes whatever the address acknowledge; each data acknowledge is checked against e too
  task xfer(input [7:0] a, input e, input integer n);
    integer j;
    begin
      u_mst.start;
      u_mst.send(a, 1'b0);
      chk("addr_ack", e, u_mst.ack);
      for (j = 0; j < n; j = j + 1) begin
        mem[n_ex % 4] = $urandom;
        u_mst.send(mem[n_ex % 4], 1'b0);
        n_ex = n_ex + 1;
        chk("data_ack", e, u_mst.ack);
      end
      u_mst.stop;
    end
  endtask
  initial begin
    i = $urandom(32'h7B09);
    repeat (10) @(negedge CLK);
    RST_N = 1'b1;
    repeat (3) @(negedge CLK);
    xfer(8'h54, 1'b0, 3);
    xfer(8'h55, 1'b1, 0);
    for (i = 0; i < 2; i = i + 1) begin
      u_mst.start;
      u_mst.send(8'h02 + i, 1'b0);
      chk("lg_ack", 1, u_mst.ack);
      chk("lg_act", 1, LEGACY_ACTIVE);
      u_mst.send($urandom, 1'b1);
      u_mst.stop;
      chk("lg_act", 0, LEGACY_ACTIVE);
      xfer(8'h54, 1'b0, 1);
    end
    BUSY = 1'b1;
    fork
      xfer(8'h54, 1'b0, 2);
      begin
        repeat (3000) @(negedge CLK);
        BUSY = 1'b0;
      end
    join
    chk("to_cnt", 0, n_to);
    SMBUS_MODE = 1'b1;
    BUSY = 1'b1;
    u_mst.start;
    u_mst.send(8'h54, 1'b0);
    u_mst.send(8'h5A, 1'b0);
    chk("to_ack", 1, u_mst.ack);
    u_mst.stop;
    chk("to_cnt", 1, n_to);
    SMBUS_MODE = 1'b0;
    BUSY = 1'b0;
    xfer(8'h54, 1'b0, 1);
    for (i = 0; i < 4; i = i + 1) begin
      RD_ADDR = i;
      @(negedge CLK);
      chk("rd_data", mem[i], RD_DATA);
    end
    chk("rx_cnt", n_ex, n_rx);
    tally_and_finish;
  end
endmodule // ilsc_target_tb_top
